// *** core/ccpa_pkg.sv ***
package ccpa_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus geometry
  localparam int          CCPA_DW            = 16;
  localparam int          CCPA_AW            = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Word indexes of the register port
  localparam logic [4:0]  CCPA_IDX_TIMER     = 5'h00;
  localparam logic [4:0]  CCPA_IDX_EDGE      = 5'h01;
  localparam logic [4:0]  CCPA_IDX_MASK1     = 5'h02;
  localparam logic [4:0]  CCPA_IDX_FLAG1     = 5'h03;
  localparam logic [4:0]  CCPA_IDX_MASK2     = 5'h04;
  localparam logic [4:0]  CCPA_IDX_FLAG2     = 5'h05;
  localparam logic [4:0]  CCPA_IDX_MASTER    = 5'h06;
  localparam logic [4:0]  CCPA_IDX_FORCE     = 5'h07;
  localparam logic [4:0]  CCPA_IDX_ACC       = 5'h08;
  localparam logic [4:0]  CCPA_IDX_DIR       = 5'h09;
  localparam logic [4:0]  CCPA_IDX_ACTION    = 5'h0a;
  localparam logic [4:0]  CCPA_IDX_CAP0      = 5'h0b;
  localparam logic [4:0]  CCPA_IDX_CMP0      = 5'h0e;
  localparam logic [4:0]  CCPA_IDX_SHARED    = 5'h12;

  ////////////////////////////////////////////////////////////////////////////
  // Channel counts
  localparam int          CCPA_NCAP          = 4;
  localparam int          CCPA_NCMP          = 5;
  localparam int          CCPA_NPIN          = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Edge select encoding
  localparam logic [1:0]  CCPA_EDGE_OFF      = 2'h0;
  localparam logic [1:0]  CCPA_EDGE_RISE     = 2'h1;
  localparam logic [1:0]  CCPA_EDGE_FALL     = 2'h2;
  localparam logic [1:0]  CCPA_EDGE_BOTH     = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Compare action encoding
  localparam logic [1:0]  CCPA_ACT_NONE      = 2'h0;
  localparam logic [1:0]  CCPA_ACT_TOGGLE    = 2'h1;
  localparam logic [1:0]  CCPA_ACT_CLEAR     = 2'h2;
  localparam logic [1:0]  CCPA_ACT_SET       = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int          CCPA_F1_OC_LSB     = 4;
  localparam int          CCPA_F2_OVF        = 0;
  localparam int          CCPA_F2_EDGE       = 1;
  localparam int          CCPA_AC_PIN        = 7;
  localparam int          CCPA_AC_MODE       = 5;
  localparam int          CCPA_AC_POL        = 4;
  localparam int          CCPA_AC_PCLK       = 3;
  localparam int          CCPA_AC_FSEL       = 2;
  localparam logic [7:0]  CCPA_AC_WMASK      = 8'h37;

  ////////////////////////////////////////////////////////////////////////////
  // Gated clock sources
  localparam logic [1:0]  CCPA_SRC_DIV512    = 2'h0;
  localparam logic [1:0]  CCPA_SRC_PCLK      = 2'h1;
  localparam logic [1:0]  CCPA_SRC_CC        = 2'h2;
  localparam logic [1:0]  CCPA_SRC_TOV       = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and counts
  localparam logic [15:0] CCPA_WORD_RST      = 16'h0000;
  localparam logic [7:0]  CCPA_BYTE_RST      = 8'h00;
  localparam logic [8:0]  CCPA_DIV512_LAST   = 9'h1ff;

endpackage

// *** core/ccpa_unit.sv ***
`timescale 1ns/100ps
// Function
// - Selected capture edge latches count, sets flag
// - Two edge bits per channel; zero disables
// - Channels capture independently, same count possible
// - Capture flag raises request when mask enabled
// - Synchronise and filter inputs, two-clock guarantee
// - Capture and count advance never collide
// - Capture reads are coherent and side-effect free
// - Every selected edge overwrites capture value
// - Compare match sets flag, no false matches
// - Master match drives masked pins from data
// - Pin shows data only when output
// - Master action wins on shared pin conflict
// - Force bit acts like match, no flag
// - Force bits self-clear, read zero, upper byte
// - Function select picks capture or compare
// - Shared register capture or compare; guarded writes
// - Event mode counts each selected pin edge
// - Gated mode counts selected clock while active
// - Edge flag on edge, overflow on wrap
// - Accumulator requests per mode, each enabled
// - Mode bit and polarity bit semantics
// - Control and count one word, reset clear
// - Timer free-runs, writable only test/freeze
// - Gated selector gets div512, pin, cc clock, timer overflow
module ccpa_unit (
  // Clock and reset
  input  wire logic                          ref_clk_i,
  input  wire logic                          nrst_i,
  // Register port
  input  wire logic [ccpa_pkg::CCPA_AW-1:0]  reg_addr_i,
  input  wire logic                          reg_wr_i,
  input  wire logic                          reg_rd_i,
  input  wire logic [1:0]                    reg_be_i,
  input  wire logic [ccpa_pkg::CCPA_DW-1:0]  reg_wdata_i,
  output logic      [ccpa_pkg::CCPA_DW-1:0]  reg_rdata_o,
  output logic                               reg_ack_o,
  // Mode and prescaler
  input  wire logic                          test_freeze_i,
  input  wire logic                          cc_tick_i,
  // Pins
  input  wire logic [2:0]                    capture_pin_i,
  input  wire logic                          shared_pin_i,
  input  wire logic                          accumulator_input_pin_i,
  input  wire logic                          ext_clock_pin_i,
  output logic      [3:0]                    compare_pin_o,
  output logic      [3:0]                    compare_oe_o,
  output logic                               shared_pin_o,
  output logic                               shared_pin_oe_o,
  // Requests
  output logic                               irq_first_o,
  output logic                               irq_second_o
);
  import ccpa_pkg::*;

  function automatic logic [15:0] ccpa_merge(input logic [15:0] old_v,
                                             input logic [15:0] new_v,
                                             input logic [1:0]  be);
    ccpa_merge = {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [15:0]          cnt_r;
  logic                 cnt_new_r;
  logic [8:0]           div_r;
  logic [7:0]           edge_r;
  logic [8:0]           mask1_r;
  logic [8:0]           flag1_r;
  logic [1:0]           mask2_r;
  logic [1:0]           flag2_r;
  logic [4:0]           mmask_r;
  logic [4:0]           mdata_r;
  logic [7:0]           pwm_r;
  logic [7:0]           acc_ctrl_r;
  logic [7:0]           acc_cnt_r;
  logic [4:0]           dir_r;
  logic [9:0]           act_r;
  logic [4:0]           out_r;
  logic [4:0]           out_nxt;
  logic [15:0]          cap_r [3];
  logic [15:0]          cmp_r [4];
  logic [15:0]          shr_r;
  logic [15:0]          cmp_v [5];
  logic [15:0]          rd_v;
  logic [15:0]          wmerge [CCPA_NPIN-1:0];
  logic [CCPA_NPIN-1:0] s1_r, s2_r, s3_r, filt_r, rise, fall;
  logic [CCPA_NCAP-1:0] cap_ev;
  logic [4:0]           match;
  logic [4:0]           force_p;
  logic [8:0]           clr1;
  logic [1:0]           clr2;
  logic                 tf, fsel, mode, pol, acc_ev, acc_deact, acc_src, acc_inc;
  logic                 div512_tick, tov_tick, acc_wr_lo;

  assign tf   = test_freeze_i;
  assign fsel = acc_ctrl_r[CCPA_AC_FSEL];
  assign mode = acc_ctrl_r[CCPA_AC_MODE];
  assign pol  = acc_ctrl_r[CCPA_AC_POL];

  function automatic logic hit(input logic [4:0] idx, input logic [4:0] a, input logic w);
    hit = w && (a == idx);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input synchroniser and filter; level changes only after two equal samples
  assign wmerge[0] = ccpa_merge(16'h0000, reg_wdata_i, reg_be_i);
  genvar gp;
  for (gp = 0; gp < CCPA_NPIN; gp++) begin : g_sync
    logic raw;
    if (gp < 3) begin : g_cap
      assign raw = capture_pin_i[gp];
    end else if (gp == 3) begin : g_shr
      assign raw = shared_pin_i;
    end else if (gp == 4) begin : g_pai
      assign raw = accumulator_input_pin_i;
    end else begin : g_pclk
      assign raw = ext_clock_pin_i;
    end
    if (gp > 0) begin : g_wm
      assign wmerge[gp] = wmerge[0];
    end
    always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
        s1_r[gp]   <= 1'b0;
        s2_r[gp]   <= 1'b0;
        s3_r[gp]   <= 1'b0;
        filt_r[gp] <= 1'b0;
      end else begin
        s1_r[gp] <= raw;
        s2_r[gp] <= s1_r[gp];
        s3_r[gp] <= s2_r[gp];
        if (s2_r[gp] == s3_r[gp]) begin
          filt_r[gp] <= s2_r[gp];
        end
      end
    end
    assign rise[gp] = (s2_r[gp] == s3_r[gp]) && s2_r[gp] && !filt_r[gp];
    assign fall[gp] = (s2_r[gp] == s3_r[gp]) && !s2_r[gp] && filt_r[gp];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared timer count and sysclk/512 tap
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      cnt_r     <= CCPA_WORD_RST;
      cnt_new_r <= 1'b0;
    end else if (tf && hit(CCPA_IDX_TIMER, reg_addr_i, reg_wr_i)) begin
      cnt_r     <= ccpa_merge(cnt_r, reg_wdata_i, reg_be_i);
      cnt_new_r <= 1'b0;
    end else begin
      cnt_r     <= cc_tick_i ? cnt_r + 16'h0001 : cnt_r;
      cnt_new_r <= cc_tick_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      div_r <= 9'h000;
    end else begin
      div_r <= div_r + 9'h001;
    end
  end
  assign div512_tick = (div_r == CCPA_DIV512_LAST);
  assign tov_tick    = cc_tick_i && (cnt_r == 16'hffff);

  ////////////////////////////////////////////////////////////////////////////
  // Capture channels; latch takes the settled count, never the one being built
  genvar gc;
  for (gc = 0; gc < CCPA_NCAP; gc++) begin : g_cap_ev
    logic [1:0] sel;
    assign sel = edge_r[2*gc +: 2];
    if (gc == 3) begin : g_last
      assign cap_ev[gc] = fsel && ((sel[0] && rise[gc]) || (sel[1] && fall[gc]));
    end else begin : g_ded
      assign cap_ev[gc] = (sel[0] && rise[gc]) || (sel[1] && fall[gc]);
    end
  end

  for (gc = 0; gc < 3; gc++) begin : g_cap_reg
    always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
        cap_r[gc] <= CCPA_WORD_RST;
      end else if (cap_ev[gc]) begin
        cap_r[gc] <= cnt_r;
      end else if (tf && hit(CCPA_IDX_CAP0 + 5'(gc), reg_addr_i, reg_wr_i)) begin
        cap_r[gc] <= ccpa_merge(cap_r[gc], reg_wdata_i, reg_be_i);
      end
    end
  end

  for (gc = 0; gc < 4; gc++) begin : g_cmp_reg
    always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
        cmp_r[gc] <= CCPA_WORD_RST;
      end else if (hit(CCPA_IDX_CMP0 + 5'(gc), reg_addr_i, reg_wr_i)) begin
        cmp_r[gc] <= ccpa_merge(cmp_r[gc], reg_wdata_i, reg_be_i);
      end
    end
    assign cmp_v[gc] = cmp_r[gc];
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      shr_r <= CCPA_WORD_RST;
    end else if (cap_ev[3]) begin
      shr_r <= cnt_r;
    end else if (hit(CCPA_IDX_SHARED, reg_addr_i, reg_wr_i) && (!fsel || tf)) begin
      shr_r <= ccpa_merge(shr_r, reg_wdata_i, reg_be_i);
    end
  end
  assign cmp_v[4] = shr_r;

  ////////////////////////////////////////////////////////////////////////////
  // Compare; only judged on a fresh count so register writes cannot false-match
  genvar gm;
  for (gm = 0; gm < CCPA_NCMP; gm++) begin : g_cmp
    if (gm == 4) begin : g_oc5
      assign match[gm] = cnt_new_r && !fsel && (cnt_r == cmp_v[gm]);
    end else begin : g_ocx
      assign match[gm] = cnt_new_r && (cnt_r == cmp_v[gm]);
    end
    always_comb begin
      out_nxt[gm] = out_r[gm];
      if (match[gm] || force_p[gm]) begin
        case (act_r[2*gm +: 2])
          CCPA_ACT_TOGGLE: out_nxt[gm] = !out_r[gm];
          CCPA_ACT_CLEAR:  out_nxt[gm] = 1'b0;
          CCPA_ACT_SET:    out_nxt[gm] = 1'b1;
          default:         out_nxt[gm] = out_r[gm];
        endcase
      end
      if ((match[0] || force_p[0]) && mmask_r[gm]) begin
        out_nxt[gm] = mdata_r[gm];
      end
    end
  end

  assign force_p = hit(CCPA_IDX_FORCE, reg_addr_i, reg_wr_i) && reg_be_i[1] ?
                   reg_wdata_i[12:8] : 5'h00;

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      out_r <= 5'h00;
    end else begin
      out_r <= out_nxt;
    end
  end

  // Latch always follows; the pin only shows it while driven
  assign compare_pin_o   = out_r[3:0];
  assign compare_oe_o    = dir_r[3:0];
  assign shared_pin_o    = out_r[4];
  assign shared_pin_oe_o = dir_r[4];

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      edge_r  <= CCPA_BYTE_RST;
      mask1_r <= 9'h000;
      mask2_r <= 2'h0;
      mmask_r <= 5'h00;
      mdata_r <= 5'h00;
      pwm_r   <= CCPA_BYTE_RST;
      dir_r   <= 5'h00;
      act_r   <= 10'h000;
    end else begin
      if (hit(CCPA_IDX_EDGE, reg_addr_i, reg_wr_i) && reg_be_i[0]) begin
        edge_r <= reg_wdata_i[7:0];
      end
      if (hit(CCPA_IDX_MASK1, reg_addr_i, reg_wr_i)) begin
        mask1_r <= {reg_be_i[1] ? reg_wdata_i[8] : mask1_r[8],
                    reg_be_i[0] ? reg_wdata_i[7:0] : mask1_r[7:0]};
      end
      if (hit(CCPA_IDX_MASK2, reg_addr_i, reg_wr_i) && reg_be_i[0]) begin
        mask2_r <= reg_wdata_i[1:0];
      end
      if (hit(CCPA_IDX_MASTER, reg_addr_i, reg_wr_i)) begin
        if (reg_be_i[1]) begin
          mmask_r <= reg_wdata_i[12:8];
        end
        if (reg_be_i[0]) begin
          mdata_r <= reg_wdata_i[4:0];
        end
      end
      if (hit(CCPA_IDX_FORCE, reg_addr_i, reg_wr_i) && reg_be_i[0]) begin
        pwm_r <= reg_wdata_i[7:0];
      end
      if (hit(CCPA_IDX_DIR, reg_addr_i, reg_wr_i) && reg_be_i[0]) begin
        dir_r <= reg_wdata_i[4:0];
      end
      if (hit(CCPA_IDX_ACTION, reg_addr_i, reg_wr_i)) begin
        act_r <= {reg_be_i[1] ? reg_wdata_i[9:8] : act_r[9:8],
                  reg_be_i[0] ? reg_wdata_i[7:0] : act_r[7:0]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags; a set in the clearing cycle survives
  assign clr1 = hit(CCPA_IDX_FLAG1, reg_addr_i, reg_wr_i) ? wmerge[1][8:0] : 9'h000;
  assign clr2 = hit(CCPA_IDX_FLAG2, reg_addr_i, reg_wr_i) ? wmerge[2][1:0] : 2'h0;

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      flag1_r <= 9'h000;
      flag2_r <= 2'h0;
    end else begin
      flag1_r <= (flag1_r & ~clr1) | {match, cap_ev};
      flag2_r <= (flag2_r & ~clr2) |
                 {mode ? acc_deact : acc_ev, acc_inc && (acc_cnt_r == 8'hff)};
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      irq_first_o  <= 1'b0;
      irq_second_o <= 1'b0;
    end else begin
      irq_first_o  <= |(flag1_r & mask1_r);
      irq_second_o <= |(flag2_r & mask2_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pulse accumulator; filter spacing caps event rate at sysclk/4
  assign acc_ev    = pol ? rise[4] : fall[4];
  assign acc_deact = pol ? fall[4] : rise[4];
  always_comb begin
    case (acc_ctrl_r[1:0])
      CCPA_SRC_DIV512: acc_src = div512_tick;
      CCPA_SRC_PCLK:   acc_src = rise[5];
      CCPA_SRC_CC:     acc_src = cc_tick_i;
      CCPA_SRC_TOV:    acc_src = tov_tick;
      default:         acc_src = 1'b0;
    endcase
  end
  assign acc_wr_lo = hit(CCPA_IDX_ACC, reg_addr_i, reg_wr_i) && reg_be_i[0];
  assign acc_inc   = !acc_wr_lo && (mode ? (acc_src && (filt_r[4] == pol)) : acc_ev);

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      acc_ctrl_r <= CCPA_BYTE_RST;
      acc_cnt_r  <= CCPA_BYTE_RST;
    end else begin
      if (hit(CCPA_IDX_ACC, reg_addr_i, reg_wr_i) && reg_be_i[1]) begin
        acc_ctrl_r <= reg_wdata_i[15:8] & CCPA_AC_WMASK;
      end
      if (acc_wr_lo) begin
        acc_cnt_r <= reg_wdata_i[7:0];
      end else if (acc_inc) begin
        acc_cnt_r <= acc_cnt_r + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port; whole word sampled in one edge keeps it coherent
  always_comb begin
    rd_v = 16'h0000;
    case (reg_addr_i)
      CCPA_IDX_TIMER:  rd_v = cnt_r;
      CCPA_IDX_EDGE:   rd_v = {8'h00, edge_r};
      CCPA_IDX_MASK1:  rd_v = {7'h00, mask1_r};
      CCPA_IDX_FLAG1:  rd_v = {7'h00, flag1_r};
      CCPA_IDX_MASK2:  rd_v = {14'h0000, mask2_r};
      CCPA_IDX_FLAG2:  rd_v = {14'h0000, flag2_r};
      CCPA_IDX_MASTER: rd_v = {3'h0, mmask_r, 3'h0, mdata_r};
      CCPA_IDX_FORCE:  rd_v = {8'h00, pwm_r};
      CCPA_IDX_ACC:    rd_v = {filt_r[4], acc_ctrl_r[6:4], filt_r[5], acc_ctrl_r[2:0],
                               acc_cnt_r};
      CCPA_IDX_DIR:    rd_v = {11'h000, dir_r};
      CCPA_IDX_ACTION: rd_v = {6'h00, act_r};
      5'h0b:           rd_v = cap_r[0];
      5'h0c:           rd_v = cap_r[1];
      5'h0d:           rd_v = cap_r[2];
      5'h0e:           rd_v = cmp_r[0];
      5'h0f:           rd_v = cmp_r[1];
      5'h10:           rd_v = cmp_r[2];
      5'h11:           rd_v = cmp_r[3];
      CCPA_IDX_SHARED: rd_v = shr_r;
      default:         rd_v = 16'h0000;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= CCPA_WORD_RST;
      reg_ack_o   <= 1'b0;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_v : reg_rdata_o;
      reg_ack_o   <= reg_rd_i || reg_wr_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  logic quiet_wr;
  assign quiet_wr = !reg_wr_i;

  cap_latch_a: assert property (cap_ev[0] |=> cap_r[0] == $past(cnt_r))
    else $error("capture latch missed count");
  cap_off_a: assert property (edge_r[1:0] == CCPA_EDGE_OFF && !tf |=> $stable(cap_r[0]))
    else $error("disabled capture changed");
  cap_flag_a: assert property (cap_ev[1] ##1 mask1_r[1] |=> irq_first_o)
    else $error("capture request missing");
  filt_pass_a: assert property ($rose(s2_r[0]) ##1 s2_r[0] ##1 s2_r[0] |-> filt_r[0])
    else $error("stable pulse filtered");
  timer_run_a: assert property (cc_tick_i && !tf |=> cnt_r == $past(cnt_r) + 16'h0001)
    else $error("timer did not advance");
  force_flag_a: assert property (force_p != 5'h00 && match == 5'h00
                                 |=> flag1_r[8:4] == $past(flag1_r[8:4]))
    else $error("force set a flag");
  force_zero_a: assert property (reg_rd_i && reg_addr_i == CCPA_IDX_FORCE
                                 |=> reg_rdata_o[15:8] == 8'h00)
    else $error("force bits read nonzero");
  master_win_a: assert property (match[0] && mmask_r[1] |=> out_r[1] == $past(mdata_r[1]))
    else $error("master action lost");
  acc_ovf_a: assert property (acc_inc && acc_cnt_r == 8'hff |=> flag2_r[CCPA_F2_OVF]
                              && acc_cnt_r == 8'h00)
    else $error("overflow not flagged");
  shr_guard_a: assert property (fsel && !tf && !cap_ev[3] |=> $stable(shr_r))
    else $error("capture register written");
  flag_hold_a: assert property (flag1_r[0] && quiet_wr |=> flag1_r[0])
    else $error("flag dropped without clear");

  cap_seen_c: cover property (cap_ev[0] ##[1:20] cap_ev[0]);
  master_c:   cover property (match[0] && mmask_r != 5'h00);
  acc_wrap_c: cover property (acc_inc && acc_cnt_r == 8'hff);
  force_c:    cover property (force_p != 5'h00);

endmodule

// *** bench/ccpa_pin_model.sv ***
`timescale 1ns/100ps
module ccpa_pin_model (
  // Clock
  input  wire logic       ref_clk_i,
  // Pins toward the block
  output logic      [2:0] capture_pin_o,
  output logic            shared_pin_o,
  output logic            acc_pin_o,
  output logic            ext_clk_o
);
  // External clock stands still throughout; no task ever drives it
  initial begin
    capture_pin_o = 3'h0;
    shared_pin_o  = 1'b0;
    acc_pin_o     = 1'b0;
    ext_clk_o     = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // High for n clocks, then low for n; n of two or more so the filter keeps it
  task automatic pulse(input logic [4:0] sel, input int n);
    @(posedge ref_clk_i);
    capture_pin_o <= capture_pin_o | sel[2:0];
    acc_pin_o     <= acc_pin_o | sel[3];
    shared_pin_o  <= shared_pin_o | sel[4];
    repeat (n) @(posedge ref_clk_i);
    capture_pin_o <= capture_pin_o & ~sel[2:0];
    acc_pin_o     <= acc_pin_o & ~sel[3];
    shared_pin_o  <= shared_pin_o & ~sel[4];
    repeat (n) @(posedge ref_clk_i);
  endtask
endmodule

// *** bench/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
  import ccpa_pkg::*;
  logic        clk, nrst, wr, rd, tf, tick, sh_o, sh_oe, irq1, irq2, ack;
  logic        acc_p, ext_p, sh_p;
  logic [4:0]  addr;
  logic [1:0]  be;
  logic [15:0] wd, rdat, v, c0, c1;
  logic [2:0]  cap_p;
  logic [3:0]  cmp, oe;
  logic [1:0]  tdiv;
  int          fail_count, tests_run;
  ccpa_unit DUT (.ref_clk_i(clk), .nrst_i(nrst), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_be_i(be), .reg_wdata_i(wd), .reg_rdata_o(rdat), .reg_ack_o(ack),
    .test_freeze_i(tf), .cc_tick_i(tick), .capture_pin_i(cap_p), .shared_pin_i(sh_p),
    .accumulator_input_pin_i(acc_p), .ext_clock_pin_i(ext_p), .compare_pin_o(cmp),
    .compare_oe_o(oe), .shared_pin_o(sh_o), .shared_pin_oe_o(sh_oe),
    .irq_first_o(irq1), .irq_second_o(irq2));
  ccpa_pin_model u_pins (.ref_clk_i(clk), .capture_pin_o(cap_p), .shared_pin_o(sh_p),
    .acc_pin_o(acc_p), .ext_clk_o(ext_p));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Counter tick every fourth clock, like the default prescaler tap
  always @(posedge clk) begin
    tdiv <= (nrst === 1'b1) ? tdiv + 2'h1 : 2'h0;
    tick <= (tdiv == 2'h3);
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Strobe for one cycle, answer sampled with the ack
  task automatic xfer(input logic w, input logic [4:0] a, input logic [1:0] b,
                      input logic [15:0] d);
    int k;
    @(posedge clk);
    wr <= w; rd <= ~w; addr <= a; be <= b; wd <= d;
    @(posedge clk);
    wr <= 1'b0; rd <= 1'b0;
    for (k = 0; k < 4 && ack !== 1'b1; k++) @(posedge clk);
    if (ack !== 1'b1) chk("ack", 16'h0001, 16'h0000);
    v = rdat;
  endtask
  task automatic wrw(input logic [4:0] a, input logic [15:0] d);
    xfer(1'b1, a, 2'h3, d);
  endtask
  task automatic results;
    $display("Checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    results();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    nrst = 1'b0; wr = 1'b0; rd = 1'b0; tf = 1'b0;
    addr = 5'h00; be = 2'h0; wd = 16'h0000;
    fail_count = 0; tests_run = 0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    xfer(1'b0, CCPA_IDX_ACC, 2'h3, 16'h0000); chk("acc reset", 16'h0000, v);
    // Rise on IC1 and IC2, IC3 left disabled
    wrw(CCPA_IDX_EDGE, 16'h0005);
    wrw(CCPA_IDX_MASK1, 16'h0002);
    u_pins.pulse(4'h7, 4);
    repeat (4) @(posedge clk);
    xfer(1'b0, CCPA_IDX_FLAG1, 2'h3, 16'h0000);
    chk("cap flags", 16'h0003, v & 16'h000f);
    chk("cap irq", 16'h0001, {15'h0, irq1});
    xfer(1'b0, CCPA_IDX_CAP0, 2'h3, 16'h0000); c0 = v;
    xfer(1'b0, CCPA_IDX_CAP0 + 5'h01, 2'h3, 16'h0000);
    chk("cap same", c0, v);
    xfer(1'b0, CCPA_IDX_CAP0, 2'h3, 16'h0000); chk("cap reread", c0, v);
    // Flag still set: second edge must still overwrite
    u_pins.pulse(4'h1, 8);
    xfer(1'b0, CCPA_IDX_CAP0, 2'h3, 16'h0000); c1 = v;
    chk("cap newer", 16'h0001, 16'(c1 != c0));
    wrw(CCPA_IDX_FLAG1, 16'h01ff);
    xfer(1'b0, CCPA_IDX_FLAG1, 2'h3, 16'h0000); chk("flag clear", 16'h0000, v);
    // Timer write only in test mode, then compare match on OC2
    tf <= 1'b1;
    wrw(CCPA_IDX_TIMER, 16'h1000);
    tf <= 1'b0;
    // OC1 and OC2 match together; the master mask sets the OC2 latch
    wrw(CCPA_IDX_CMP0 + 5'h01, 16'h1008);
    wrw(CCPA_IDX_CMP0, 16'h1008);
    wrw(CCPA_IDX_MASTER, 16'h0202);
    wrw(CCPA_IDX_MASK1, 16'h0020);
    repeat (40) @(posedge clk);
    xfer(1'b0, CCPA_IDX_FLAG1, 2'h3, 16'h0000);
    chk("oc2 flag", 16'h0020, v & 16'h0020);
    chk("oc1 flag", 16'h0010, v & 16'h0010);
    chk("master match", 16'h0002, {12'h0, cmp & 4'h2});
    chk("irq1", 16'h0001, {15'h0, irq1});
    wrw(CCPA_IDX_FLAG1, 16'h01ff);
    // Forced clear on OC2, then master forced set through the mask
    wrw(CCPA_IDX_DIR, 16'h0002);
    wrw(CCPA_IDX_ACTION, 16'h0008);
    xfer(1'b1, CCPA_IDX_FORCE, 2'h2, 16'h0200);
    repeat (2) @(posedge clk);
    chk("force pin", 16'h0000, {12'h0, cmp & 4'h2});
    chk("oe", 16'h0002, {12'h0, oe});
    xfer(1'b0, CCPA_IDX_FORCE, 2'h3, 16'h0000); chk("force rd", 16'h0000, v);
    xfer(1'b0, CCPA_IDX_FLAG1, 2'h3, 16'h0000);
    chk("no flag", 16'h0000, v & 16'h01f0);
    wrw(CCPA_IDX_MASTER, 16'h0202);
    xfer(1'b1, CCPA_IDX_FORCE, 2'h2, 16'h0100);
    repeat (2) @(posedge clk);
    chk("master pin", 16'h0002, {12'h0, cmp & 4'h2});
    // Event count on rising edges across the wrap
    wrw(CCPA_IDX_ACC, 16'h10fe);
    wrw(CCPA_IDX_MASK2, 16'h0002);
    u_pins.pulse(4'h8, 4);
    u_pins.pulse(4'h8, 4);
    repeat (4) @(posedge clk);
    xfer(1'b0, CCPA_IDX_ACC, 2'h3, 16'h0000); chk("acc cnt", 16'h1000, v);
    xfer(1'b0, CCPA_IDX_FLAG2, 2'h3, 16'h0000); chk("flag2", 16'h0003, v);
    chk("irq2", 16'h0001, {15'h0, irq2});
    // OC5 forced set on the shared pin while it drives
    wrw(CCPA_IDX_DIR, 16'h0010);
    wrw(CCPA_IDX_ACTION, 16'h0300);
    xfer(1'b1, CCPA_IDX_FORCE, 2'h2, 16'h1000);
    repeat (2) @(posedge clk);
    chk("shared pin", 16'h0003, {14'h0, sh_oe, sh_o});
    // Pin as IC4: writes refused, falling edge captured beside IC3 on both
    wrw(CCPA_IDX_ACC, 16'h0400);
    wrw(CCPA_IDX_SHARED, 16'h1234);
    xfer(1'b0, CCPA_IDX_SHARED, 2'h3, 16'h0000);
    chk("shared guard", 16'h0000, v);
    wrw(CCPA_IDX_EDGE, 16'h00b0);
    u_pins.pulse(5'h14, 4);
    repeat (4) @(posedge clk);
    xfer(1'b0, CCPA_IDX_FLAG1, 2'h3, 16'h0000);
    chk("ic3 ic4 flags", 16'h000c, v & 16'h000f);
    xfer(1'b0, CCPA_IDX_CAP0 + 5'h02, 2'h3, 16'h0000);
    c0 = v;
    xfer(1'b0, CCPA_IDX_SHARED, 2'h3, 16'h0000);
    chk("ic4 value", c0, v);
    // Gated on a high level with the cc tick: ten ticks in forty clocks
    wrw(CCPA_IDX_FLAG2, 16'h0003);
    wrw(CCPA_IDX_ACC, 16'h3600);
    u_pins.pulse(5'h08, 40);
    xfer(1'b0, CCPA_IDX_ACC, 2'h3, 16'h0000);
    chk("gated count", 16'h360a, v);
    xfer(1'b0, CCPA_IDX_FLAG2, 2'h3, 16'h0000);
    chk("gated edge", 16'h0002, v);
    results();
  end
endmodule
